// [adc_tuning_and_mode_regs.sv]
/*
 tuning and low-speed mode register bank behind an APB slave;
 assumes a synchronous APB master on clk_sys_in, zero wait states.
*/
// Our own choices: the APB interface to the registers and the address map.
// Summary of operation
// - trim[9:7] at bits 7-5, reset 000
// - trim bit 11 at bit 5, reset 0
// - trim bit 10 at bit 1, reset 0
// - channel B slow enable at bit 0
// - channel A slow enable at bit 3
// - global enable gates both channel enables
// - swing code 11 follows select, 00 not
`timescale 1ns/1ps
`default_nettype none
`include "slow_mode_map.svh"
module adc_tuning_and_mode_regs (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  output logic [2:0]       perf_trim_hi_out,
  output logic             perf_trim_eleven_out,
  output logic             perf_trim_ten_out,
  output logic             chan_a_slow_enable_out,
  output logic             chan_b_slow_enable_out,
  output logic             swing_follow_out
);
  logic [2:0] trim_hi_q;
  logic       chan_b_q;
  logic       trim_eleven_q;
  logic       trim_ten_q;
  logic       slow_global_q;
  logic [1:0] swing_q;
  logic       chan_a_q;
  logic       chan_a_eff;
  logic       chan_b_eff;
  logic       swing_eff;
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic [7:0] rd_byte;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFF_TRIM_HIGH_B) || (a == `OFF_TRIM_ELEVEN) ||
             (a == `OFF_SLOW_GLOBAL) || (a == `OFF_SWING_OVR) ||
             (a == `OFF_CHAN_A_SLOW) || (a == `OFF_MODE_STATUS);
  endfunction

  assign hit        = mapped(paddr_in);
  assign pready_out = 1'b1;
  assign wr_en = psel_in & penable_in & pwrite_in & pstrb_in[0] & hit;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;

  // trim[9:7] and channel B enable
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trim_hi_q <= 3'h0;
      chan_b_q  <= 1'b0;
    end else if (wr_en && paddr_in == `OFF_TRIM_HIGH_B) begin
      trim_hi_q <= pwdata_in[`POS_TRIM_HI_LSB +: 3];
      chan_b_q  <= pwdata_in[`POS_CHAN_B_SLOW];
    end
  end

  // trim bits 11 and 10
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trim_eleven_q <= 1'b0;
      trim_ten_q    <= 1'b0;
    end else if (wr_en && paddr_in == `OFF_TRIM_ELEVEN) begin
      trim_eleven_q <= pwdata_in[`POS_TRIM_ELEVEN];
      trim_ten_q    <= pwdata_in[`POS_TRIM_TEN];
    end
  end

  // global low-speed enable
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slow_global_q <= 1'b0;
    end else if (wr_en && paddr_in == `OFF_SLOW_GLOBAL) begin
      slow_global_q <= pwdata_in[`POS_SLOW_GLOBAL];
    end
  end

  // swing override code, stored as written
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      swing_q <= 2'h0;
    end else if (wr_en && paddr_in == `OFF_SWING_OVR) begin
      swing_q <= pwdata_in[`POS_SWING_LSB +: 2];
    end
  end

  // channel A enable
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_a_q <= 1'b0;
    end else if (wr_en && paddr_in == `OFF_CHAN_A_SLOW) begin
      chan_a_q <= pwdata_in[`POS_CHAN_A_SLOW];
    end
  end

  slow_mode_decode u_decode (
    .swing_field_in   (swing_q),
    .slow_global_in   (slow_global_q),
    .chan_a_bit_in    (chan_a_q),
    .chan_b_bit_in    (chan_b_q),
    .chan_a_slow_out  (chan_a_eff),
    .chan_b_slow_out  (chan_b_eff),
    .swing_follow_out (swing_eff)
  );

  // read mux, reserved bits zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr_in)
      `OFF_TRIM_HIGH_B: begin
        rd_byte = {trim_hi_q, 4'h0, chan_b_q};
      end
      `OFF_TRIM_ELEVEN: begin
        rd_byte = {2'h0, trim_eleven_q, 3'h0, trim_ten_q, 1'b0};
      end
      `OFF_SLOW_GLOBAL: begin
        rd_byte = {3'h0, slow_global_q, 4'h0};
      end
      `OFF_SWING_OVR: begin
        rd_byte = {6'h00, swing_q};
      end
      `OFF_CHAN_A_SLOW: begin
        rd_byte = {4'h0, chan_a_q, 3'h0};
      end
      `OFF_MODE_STATUS: begin
        rd_byte = {5'h00, swing_eff, chan_a_eff, chan_b_eff};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // read data loaded in setup, stands through access
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_out <= {24'h00_0000, rd_byte};
    end
  end

  always_comb begin
    pslverr_out = psel_in & penable_in & ~hit;
  end

  // configuration outputs from flip-flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      perf_trim_hi_out       <= 3'h0;
      perf_trim_eleven_out   <= 1'b0;
      perf_trim_ten_out      <= 1'b0;
      chan_a_slow_enable_out <= 1'b0;
      chan_b_slow_enable_out <= 1'b0;
      swing_follow_out       <= 1'b0;
    end else begin
      perf_trim_hi_out       <= trim_hi_q;
      perf_trim_eleven_out   <= trim_eleven_q;
      perf_trim_ten_out      <= trim_ten_q;
      chan_a_slow_enable_out <= chan_a_eff;
      chan_b_slow_enable_out <= chan_b_eff;
      swing_follow_out       <= swing_eff;
    end
  end

  sequence s_global_off;
    !slow_global_q;
  endsequence

  a_global_gate_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in) s_global_off |=> !chan_a_slow_enable_out)
    else $error("channel A slow active without global enable");

  a_global_gate_b: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in) s_global_off |=> !chan_b_slow_enable_out)
    else $error("channel B slow active without global enable");

  a_chan_a_follow: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (slow_global_q && chan_a_q) |=> chan_a_slow_enable_out)
    else $error("channel A slow enable not applied");

  a_chan_b_write: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_HIGH_B)
      |=> chan_b_q == $past(pwdata_in[0]))
    else $error("channel B bit not stored");

  a_trim_hi_write: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_HIGH_B)
      |=> ##1 perf_trim_hi_out == $past(pwdata_in[7:5], 2))
    else $error("trim high field not applied");

  a_trim_eleven: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_ELEVEN)
      |=> trim_eleven_q == $past(pwdata_in[5]))
    else $error("trim eleven not stored");

  a_trim_ten: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_ELEVEN)
      |=> trim_ten_q == $past(pwdata_in[1]))
    else $error("trim ten not stored");

  a_swing_decode: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (swing_q != 2'b11) |=> !swing_follow_out)
    else $error("swing follows select without code 11");

  a_hold_value: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    !wr_en |=> $stable(swing_q) && $stable(slow_global_q))
    else $error("register changed without a write");

  sequence s_masked_write;
    psel_in && penable_in && pwrite_in && !pstrb_in[0];
  endsequence

  sequence s_swing_read_setup;
    psel_in && !penable_in && !pwrite_in && paddr_in == `OFF_SWING_OVR;
  endsequence

  a_trim_hi_stored: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_HIGH_B)
      |=> trim_hi_q == $past(pwdata_in[7:5]))
    else $error("trim high field not stored");

  a_trim_eleven_out: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_ELEVEN)
      |=> ##1 perf_trim_eleven_out == $past(pwdata_in[5], 2))
    else $error("trim eleven not applied");

  a_trim_ten_out: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_TRIM_ELEVEN)
      |=> ##1 perf_trim_ten_out == $past(pwdata_in[1], 2))
    else $error("trim ten not applied");

  a_chan_b_follow: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (slow_global_q && chan_b_q) |=> chan_b_slow_enable_out)
    else $error("channel B slow enable not applied");

  a_chan_b_clear: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    !chan_b_q |=> !chan_b_slow_enable_out)
    else $error("channel B slow active with its bit clear");

  a_chan_a_write: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_CHAN_A_SLOW)
      |=> chan_a_q == $past(pwdata_in[3]))
    else $error("channel A bit not stored");

  a_chan_a_clear: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    !chan_a_q |=> !chan_a_slow_enable_out)
    else $error("channel A slow active with its bit clear");

  a_global_write: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_SLOW_GLOBAL)
      |=> slow_global_q == $past(pwdata_in[4]))
    else $error("global slow enable not stored");

  a_swing_write: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (wr_en && paddr_in == `OFF_SWING_OVR)
      |=> swing_q == $past(pwdata_in[1:0]))
    else $error("swing code not stored");

  a_swing_follow_on: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    (swing_q == slow_mode_pkg::SWING_ON) |=> swing_follow_out)
    else $error("swing code 11 not followed");

  a_swing_readback: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    s_swing_read_setup |=> prdata_out == {30'h0, $past(swing_q)})
    else $error("swing code read back wrong");

  a_strobe_masked: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    s_masked_write |=> $stable(trim_hi_q) && $stable(chan_b_q) &&
      $stable(trim_eleven_q) && $stable(trim_ten_q))
    else $error("masked write changed a trim register");

  a_hold_others: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    !wr_en |=> $stable(trim_hi_q) && $stable(chan_b_q) &&
      $stable(trim_eleven_q) && $stable(trim_ten_q) && $stable(chan_a_q))
    else $error("trim or channel bit changed without a write");
endmodule
`default_nettype wire

// [adc_tuning_and_mode_regs_tb.sv]
/*
 self-checking bench for the tuning and mode register bank;
 assumes the design's map header and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slow_mode_map.svh"
module adc_tuning_and_mode_regs_tb;
  logic        clk_sys_in;
  logic        rst_n_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [3:0]  pstrb_in;
  logic        pready_out;
  logic        pslverr_out;
  logic [31:0] prdata_out;
  logic [2:0]  trim_hi;
  logic        trim_11;
  logic        trim_10;
  logic        slow_a;
  logic        slow_b;
  logic        swing;
  int          failures;
  int          checks;
  adc_tuning_and_mode_regs dut_u (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .perf_trim_hi_out(trim_hi), .perf_trim_eleven_out(trim_11),
    .perf_trim_ten_out(trim_10), .chan_a_slow_enable_out(slow_a),
    .chan_b_slow_enable_out(slow_b), .swing_follow_out(swing));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_outs(input logic [7:0] exp);
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    cmp_word({24'h0, trim_hi, trim_11, trim_10, slow_a, slow_b, swing},
             {24'h0, exp});
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) begin
      @(posedge clk_sys_in);
    end
    er = pslverr_out;
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, a, d, 4'hF, rd, er);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp,
                        input logic eer);
    logic [31:0] rd;
    logic        er;
    xfer(1'b0, a, 32'h0, 4'h0, rd, er);
    cmp_word({31'h0, er}, {31'h0, eer});
    cmp_word(rd, exp);
  endtask
  task automatic t_reset();
    logic [11:0] offs [6];
    offs = '{`OFF_TRIM_HIGH_B, `OFF_TRIM_ELEVEN, `OFF_SLOW_GLOBAL,
             `OFF_SWING_OVR, `OFF_CHAN_A_SLOW, `OFF_MODE_STATUS};
    cmp_outs(8'h00);
    foreach (offs[i]) chk_rd(offs[i], 32'h0, 1'b0);
  endtask
  task automatic t_trim();
    wr(`OFF_TRIM_HIGH_B, 32'h0000_00E0);
    wr(`OFF_TRIM_ELEVEN, 32'h0000_0022);
    cmp_outs(8'hF8);
    chk_rd(`OFF_TRIM_HIGH_B, 32'h0000_00E0, 1'b0);
    chk_rd(`OFF_TRIM_ELEVEN, 32'h0000_0022, 1'b0);
  endtask
  task automatic t_slow();
    wr(`OFF_TRIM_HIGH_B, 32'h0000_00E1);
    wr(`OFF_CHAN_A_SLOW, 32'h0000_0008);
    cmp_outs(8'hF8);
    wr(`OFF_SLOW_GLOBAL, 32'h0000_0010);
    cmp_outs(8'hFE);
    chk_rd(`OFF_MODE_STATUS, 32'h0000_0003, 1'b0);
    wr(`OFF_CHAN_A_SLOW, 32'h0000_0000);
    cmp_outs(8'hFA);
    wr(`OFF_SLOW_GLOBAL, 32'h0000_0000);
    cmp_outs(8'hF8);
  endtask
  task automatic t_swing();
    logic [1:0] c;
    for (int i = 0; i < 3; i++) begin
      c = (i == 1) ? 2'h0 : 2'h3;
      wr(`OFF_SWING_OVR, {30'h0, c});
      cmp_outs({7'h7C, c == 2'h3});
      chk_rd(`OFF_SWING_OVR, {30'h0, c}, 1'b0);
      chk_rd(`OFF_MODE_STATUS, {29'h0, c == 2'h3, 2'h0}, 1'b0);
    end
  endtask
  task automatic t_refuse();
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, 12'h020, 32'h0000_00FF, 4'hF, rd, er);
    cmp_word({31'h0, er}, 32'h1);
    chk_rd(12'h020, 32'h0, 1'b1);
    xfer(1'b1, `OFF_TRIM_HIGH_B, 32'h0, 4'h0, rd, er);
    chk_rd(`OFF_TRIM_HIGH_B, 32'h0000_00E1, 1'b0);
    cmp_outs(8'hF9);
    wr(`OFF_SLOW_GLOBAL, 32'h0000_0010);
    chk_rd(`OFF_SLOW_GLOBAL, 32'h0000_0010, 1'b0);
  endtask
  task automatic t_reset2();
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    cmp_outs(8'h00);
    chk_rd(`OFF_TRIM_HIGH_B, 32'h0, 1'b0);
  endtask
  initial begin
    failures = 0;
    checks = 0;
    rst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    pstrb_in = 4'h0;
    repeat (3) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_trim();
    t_slow();
    t_swing();
    t_refuse();
    t_reset2();
    tally_and_finish();
  end
  initial begin
    #50000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [slow_mode_decode.sv]
/*
 decode of the low-speed gating and swing-override field;
 assumes register values settle synchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module slow_mode_decode (
  input  wire logic [1:0] swing_field_in,
  input  wire logic       slow_global_in,
  input  wire logic       chan_a_bit_in,
  input  wire logic       chan_b_bit_in,
  output logic            chan_a_slow_out,
  output logic            chan_b_slow_out,
  output logic            swing_follow_out
);
  // global gate over both channels
  assign chan_a_slow_out = slow_global_in & chan_a_bit_in;
  assign chan_b_slow_out = slow_global_in & chan_b_bit_in;
  // only code 11 passes swing control on
  assign swing_follow_out =
    (slow_mode_pkg::swing_mode_e'(swing_field_in) ==
     slow_mode_pkg::SWING_ON);
endmodule
`default_nettype wire

// [slow_mode_map.svh]
/*
 register offsets, field positions and reset values of the converter
 tuning and mode registers; assumes an APB slave with 32-bit data.
*/
`ifndef SLOW_MODE_MAP_SVH
`define SLOW_MODE_MAP_SVH

`define OFF_TRIM_HIGH_B    12'h000
`define OFF_TRIM_ELEVEN    12'h004
`define OFF_SLOW_GLOBAL    12'h008
`define OFF_SWING_OVR      12'h00C
`define OFF_CHAN_A_SLOW    12'h010
`define OFF_MODE_STATUS    12'h014

`define POS_TRIM_HI_LSB    5
`define POS_CHAN_B_SLOW    0
`define POS_TRIM_ELEVEN    5
`define POS_TRIM_TEN       1
`define POS_SLOW_GLOBAL    4
`define POS_CHAN_A_SLOW    3
`define POS_SWING_LSB      0

`define RST_REG8           8'h00

`endif

// [slow_mode_pkg.sv]
/*
 types shared by the tuning and mode register bank; assumes nothing.
*/
`default_nettype none
package slow_mode_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic [1:0] {
    SWING_OFF  = 2'b00,
    SWING_RSV1 = 2'b01,
    SWING_RSV2 = 2'b10,
    SWING_ON   = 2'b11
  } swing_mode_e;
endpackage
`default_nettype wire
